// ==== rtl/pca_pkg.sv ====
// Purpose: Shared constants and types for the ADC serial readout block
// Assumes: Crystal near 32.768 kHz, system clock 125 MHz
// Notes:   Counts below are in crystal periods unless named otherwise
package pca_pkg;

  // ------------------------------------------------------------------
  // Word and timing
  // ------------------------------------------------------------------
  localparam int WORD_BITS        = 24;
  localparam int OSC_HZ           = 32768;
  localparam int DECIM_A          = 69;
  localparam int DECIM_B          = 8;
  localparam int DECIM_C          = 3;
  localparam int CONV_PERIOD_OSC  = DECIM_A * DECIM_B * DECIM_C;
  localparam int SETTLE_PERIODS   = 2;
  localparam int PLL_LOCK_OSC     = 4;
  localparam int BUF_DEPTH        = 2;

  // ------------------------------------------------------------------
  // Pin levels
  // ------------------------------------------------------------------
  localparam logic MODE_MASTER = 1'h0;
  localparam logic SCLK_IDLE   = 1'h1;
  localparam logic LINE_BUSY   = 1'h1;
  localparam logic LINE_READY  = 1'h0;

  // ------------------------------------------------------------------
  // Synchroniser bit positions
  // ------------------------------------------------------------------
  localparam int SYNC_N    = 5;
  localparam int SYNC_OSC  = 4;
  localparam int SYNC_SCLK = 3;
  localparam int SYNC_CSN  = 2;
  localparam int SYNC_MODE = 1;
  localparam int SYNC_PAIR = 0;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_LOCK,
    ST_BUSY,
    ST_AVAIL,
    ST_SHIFT
  } pca_state_t;

endpackage

// ==== rtl/pca_buf.sv ====
// Purpose: Small valid/ready FIFO between result source and shifter
// Assumes: Single clock, flush has priority over push
// Notes:   Full and empty are exact; ready drops when full
`timescale 1ns/1ps
module pca_buf #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  output      logic             in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output      logic             out_valid_out,
  input  wire logic             out_ready_in,
  output      logic [WIDTH-1:0] out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  wire              push;
  wire              pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // ------------------------------------------------------------------
  // Handshake
  // ------------------------------------------------------------------
  assign in_ready_out  = (count_r != (AW + 1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out  = mem_r[rd_ptr_r];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      count_r <= count_r + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

endmodule

// ==== rtl/pca_readout.sv ====
// Purpose: Conversion sequencing and serial readout of a two-pair ADC
// Assumes: Pins are asynchronous; result source runs on clk_in
// Notes:   Pin outputs lag internal state by one clock (registered)
//
// Contract
// R1: Master drives serial clock, one crystal period
// R2: Slave mode: host supplies serial clock
// R3: Slave reads may pause; shift position kept
// R4: Chip select low: lock PLL, then convert
// R5: Chip select high: abort, float pins, discard
// R6: Line high while conversion incomplete
// R7: Line low when result ready
// R8: Unread result: line high before next update
// R9: Master: line low half cycle before clocks
// R10: Data changes after falling edge, sampled rising
// R11: Mode low master, mode high slave
// R12: One result every 69*8*3 crystal periods
// R13: Two output periods settle before first result
// R14: Select low first pair, high second pair
// R15: Master: exactly 24 clocks, then idle high
// R16: Host idles clock high, gives 24 pulses
// R17: Results coded offset binary
// R18: Most significant bit shifted first
`timescale 1ns/1ps
module pca_readout
  import pca_pkg::*;
#(
  parameter int CONV_PERIOD = pca_pkg::CONV_PERIOD_OSC,
  parameter int PLL_LOCK    = pca_pkg::PLL_LOCK_OSC,
  parameter int DEPTH       = pca_pkg::BUF_DEPTH
) (
  input  wire logic                          clk_in,
  input  wire logic                          resetn_in,
  input  wire logic                          crystal_osc_clock_in,
  input  wire logic                          cs_n_in,
  input  wire logic                          mode_in,
  input  wire logic                          input_pair_select_in,
  input  wire logic                          sclk_in,
  output      logic                          sclk_out,
  output      logic                          sclk_oe_out,
  output      logic                          dout_rdy_out,
  output      logic                          dout_rdy_oe_out,
  input  wire logic                          result_valid_in,
  output      logic                          result_ready_out,
  input  wire logic [pca_pkg::WORD_BITS-1:0] result_data_in,
  output      logic                          pair_select_out,
  output      logic                          converting_out
);

  localparam int CW = $clog2(CONV_PERIOD);
  localparam int LW = (PLL_LOCK > 1) ? $clog2(PLL_LOCK) : 1;
  localparam int BW = $clog2(WORD_BITS + 1);
  localparam int MSB = WORD_BITS - 1;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  wire  [SYNC_N-1:0] raw_pins;
  logic [SYNC_N-1:0] sync1_r;
  logic [SYNC_N-1:0] sync2_r;
  logic [SYNC_N-1:0] prev_r;

  assign raw_pins = {crystal_osc_clock_in, sclk_in, cs_n_in, mode_in,
                     input_pair_select_in};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          sync1_r[gi] <= 1'h1;
          sync2_r[gi] <= 1'h1;
          prev_r[gi]  <= 1'h1;
        end else begin
          sync1_r[gi] <= raw_pins[gi];
          sync2_r[gi] <= sync1_r[gi];
          prev_r[gi]  <= sync2_r[gi];
        end
      end
    end
  endgenerate

  wire crystal_osc_clock_rise = sync2_r[SYNC_OSC] && !prev_r[SYNC_OSC];
  wire crystal_osc_clock_fall = !sync2_r[SYNC_OSC] && prev_r[SYNC_OSC];
  wire sclk_rise = sync2_r[SYNC_SCLK] && !prev_r[SYNC_SCLK];
  wire sclk_fall = !sync2_r[SYNC_SCLK] && prev_r[SYNC_SCLK];
  wire cs_act    = !sync2_r[SYNC_CSN];
  wire pair_s    = sync2_r[SYNC_PAIR];
  wire master    = (sync2_r[SYNC_MODE] == MODE_MASTER);  // [R11]

  // ------------------------------------------------------------------
  // State and datapath registers
  // ------------------------------------------------------------------
  pca_state_t     state_r;
  pca_state_t     state_nxt;
  logic [CW-1:0]  conv_cnt_r;
  logic [LW-1:0]  lock_cnt_r;
  logic [1:0]     settle_cnt_r;
  logic [MSB:0]   shreg_r;
  logic [BW-1:0]  bit_cnt_r;
  logic           started_r;
  logic           sclk_r;
  logic           active_pair_r;
  logic           dout_r;
  logic           dout_oe_r;
  logic           sclk_oe_r;
  logic           buf_valid;
  logic [MSB:0]   buf_data;

  wire converting = (state_r == ST_BUSY) || (state_r == ST_AVAIL) ||
                    (state_r == ST_SHIFT);
  wire restart    = converting && (pair_s != active_pair_r);   // [R13]
  wire upd_ev     = converting && crystal_osc_clock_rise &&
                    (conv_cnt_r == CW'(CONV_PERIOD - 1));      // [R12]
  wire upd_pre    = converting && crystal_osc_clock_rise &&
                    (conv_cnt_r == CW'(CONV_PERIOD - 2));      // [R8]
  wire settled    = (settle_cnt_r == 2'(SETTLE_PERIODS));
  wire pop_ev     = upd_ev && (state_r == ST_BUSY);
  wire present    = pop_ev && settled && buf_valid;            // [R13]
  wire lock_done  = crystal_osc_clock_rise && (lock_cnt_r == LW'(PLL_LOCK - 1));
  wire flush      = !converting || restart;                    // [R5]

  // Master edges come from the crystal; slave edges from the host clock
  wire fall_ev = master ? ((state_r == ST_SHIFT) && crystal_osc_clock_rise)
                        : ((state_r == ST_AVAIL) && sclk_fall);  // [R10]
  wire rise_ev = master ? ((state_r == ST_SHIFT) && crystal_osc_clock_fall)
                        : ((state_r == ST_AVAIL) && sclk_rise);
  wire last_bit = rise_ev && started_r &&
                  (bit_cnt_r == BW'(WORD_BITS - 1));           // [R15]
  wire line_val = (state_r == ST_AVAIL || state_r == ST_SHIFT) ?
                  (started_r ? shreg_r[MSB] : LINE_READY)      // [R7] [R18]
                  : LINE_BUSY;                                 // [R6]

  // ------------------------------------------------------------------
  // Result buffer
  // ------------------------------------------------------------------
  pca_buf #(
    .WIDTH (WORD_BITS),
    .DEPTH (DEPTH)
  ) u_buf (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .flush_in      (flush),
    .in_valid_in   (result_valid_in),
    .in_ready_out  (result_ready_out),
    .in_data_in    (result_data_in),
    .out_valid_out (buf_valid),
    .out_ready_in  (pop_ev),
    .out_data_out  (buf_data)
  );

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_STANDBY: begin
        state_nxt = ST_LOCK;                                   // [R4]
      end
      ST_LOCK: begin
        if (lock_done) begin
          state_nxt = ST_BUSY;                                 // [R4]
        end
      end
      ST_BUSY: begin
        if (present) begin
          state_nxt = ST_AVAIL;                                // [R7]
        end
      end
      ST_AVAIL: begin
        if (upd_pre) begin
          state_nxt = ST_BUSY;                                 // [R8]
        end else if (master && crystal_osc_clock_fall) begin
          state_nxt = ST_SHIFT;                                // [R9]
        end else if (!master && last_bit) begin
          state_nxt = ST_BUSY;                                 // [R16]
        end
      end
      ST_SHIFT: begin
        if (last_bit) begin
          state_nxt = ST_BUSY;                                 // [R15]
        end
      end
      default: begin
        state_nxt = ST_STANDBY;
      end
    endcase
    if (!cs_act) begin
      state_nxt = ST_STANDBY;                                  // [R5]
    end else if (restart) begin
      state_nxt = ST_BUSY;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= ST_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Lock wait and conversion timebase, counted in crystal periods
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lock_cnt_r <= '0;
      conv_cnt_r <= '0;
    end else begin
      lock_cnt_r <= (state_r == ST_LOCK && crystal_osc_clock_rise) ?
                    lock_cnt_r + LW'(1) :
                    ((state_r == ST_LOCK) ? lock_cnt_r : '0);
      if (!converting || restart) begin
        conv_cnt_r <= '0;
      end else if (crystal_osc_clock_rise) begin
        conv_cnt_r <= upd_ev ? '0 : conv_cnt_r + CW'(1);       // [R12]
      end
    end
  end

  // Settling: discard results until two periods have passed
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      settle_cnt_r  <= '0;
      active_pair_r <= 1'h0;
    end else if (!converting || restart) begin
      settle_cnt_r  <= '0;                                     // [R13]
      active_pair_r <= pair_s;                                 // [R14]
    end else if (upd_ev && !settled) begin
      settle_cnt_r  <= settle_cnt_r + 2'h1;
    end
  end

  // ------------------------------------------------------------------
  // Output shifter
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shreg_r   <= '0;
      started_r <= 1'h0;
      bit_cnt_r <= '0;
    end else if (present) begin
      shreg_r   <= {~buf_data[MSB], buf_data[MSB-1:0]};        // [R17]
      started_r <= 1'h0;
      bit_cnt_r <= '0;
    end else begin
      if (fall_ev) begin
        started_r <= 1'h1;
      end
      if (fall_ev && started_r) begin
        shreg_r <= {shreg_r[MSB-1:0], 1'h0};                   // [R10] [R18]
      end
      if (rise_ev && started_r) begin
        bit_cnt_r <= bit_cnt_r + BW'(1);                       // [R3]
      end
    end
  end

  // Serial clock is the inverted crystal only while a word is shifting
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_r    <= SCLK_IDLE;
      dout_r    <= LINE_BUSY;
      dout_oe_r <= 1'h0;
      sclk_oe_r <= 1'h0;
    end else begin
      if (state_r != ST_SHIFT || crystal_osc_clock_fall) begin
        sclk_r <= SCLK_IDLE;                                   // [R15]
      end else if (crystal_osc_clock_rise) begin
        sclk_r <= ~SCLK_IDLE;                                  // [R1]
      end
      dout_r    <= line_val;
      dout_oe_r <= cs_act;                                     // [R5]
      sclk_oe_r <= cs_act && master;                           // [R1] [R2]
    end
  end

  assign sclk_out        = sclk_r;
  assign sclk_oe_out     = sclk_oe_r;
  assign dout_rdy_out    = dout_r;
  assign dout_rdy_oe_out = dout_oe_r;
  assign pair_select_out = active_pair_r;                      // [R14]
  assign converting_out  = converting;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_load;
    state_r == ST_BUSY ##1 state_r == ST_AVAIL;
  endsequence

  sequence s_go_master;
    state_r == ST_AVAIL && master ##1 state_r == ST_SHIFT;
  endsequence

  sequence s_word_end;
    state_r == ST_SHIFT && cs_act && !restart ##1 state_r == ST_BUSY;
  endsequence

  a_standby_float: assert property (        // [R5]
    !cs_act |=> !dout_rdy_oe_out && !sclk_oe_out && state_r == ST_STANDBY)
    else $error("pins not floated after deselect");
  a_abort_discard: assert property (        // [R5]
    state_r == ST_STANDBY |=> !buf_valid)
    else $error("result kept in standby");
  a_lock_start: assert property (           // [R4]
    state_r == ST_STANDBY && cs_act |=> state_r == ST_LOCK)
    else $error("no lock after select");
  a_busy_line_high: assert property (       // [R6]
    state_r == ST_BUSY |=> dout_rdy_out == LINE_BUSY)
    else $error("ready line low while busy");
  a_ready_line_low: assert property (       // [R7]
    s_load |=> dout_rdy_out == LINE_READY)
    else $error("ready line not low on result");
  a_unread_release: assert property (       // [R8]
    state_r == ST_AVAIL && upd_pre && cs_act |=> state_r == ST_BUSY)
    else $error("unread result not released before update");
  a_master_pre_low: assert property (       // [R9]
    s_go_master |-> $past(crystal_osc_clock_fall) && dout_rdy_out == LINE_READY)
    else $error("clocks began without low ready phase");
  a_sclk_mode_drive: assert property (      // [R1] [R11]
    cs_act && master |=> sclk_oe_out)
    else $error("master not driving serial clock");
  a_sclk_slave_float: assert property (     // [R2] [R11]
    !master |=> !sclk_oe_out)
    else $error("slave driving serial clock");
  a_shift_on_fall: assert property (        // [R10]
    !$past(present) && $changed(shreg_r) |-> $past(fall_ev))
    else $error("data changed without falling edge");
  a_slave_pause_hold: assert property (     // [R3]
    !master && state_r == ST_AVAIL && !sclk_fall && !sclk_rise &&
    !upd_pre && cs_act && !restart |=> $stable(bit_cnt_r) &&
    $stable(shreg_r) && state_r == ST_AVAIL)
    else $error("shift position lost during pause");
  a_word_length: assert property (          // [R15]
    s_word_end |-> bit_cnt_r == BW'(WORD_BITS))
    else $error("word not exactly twenty-four clocks");
  a_sclk_idle_high: assert property (       // [R15]
    state_r == ST_BUSY |=> sclk_out == SCLK_IDLE)
    else $error("serial clock not idle high");
  a_rate_bound: assert property (           // [R12]
    crystal_osc_clock_rise && converting && !restart && conv_cnt_r != '0 |=>
    conv_cnt_r == $past(conv_cnt_r) + CW'(1) ||
    $past(conv_cnt_r) == CW'(CONV_PERIOD - 1))
    else $error("conversion timebase broken");
  a_settle_gate: assert property (          // [R13]
    s_load |-> $past(settle_cnt_r) == 2'(SETTLE_PERIODS))
    else $error("result presented before settling");
  a_pair_follow: assert property (          // [R14]
    !converting |=> pair_select_out == $past(pair_s))
    else $error("active pair not following select");
  a_offset_code: assert property (          // [R17]
    present |=> shreg_r[MSB] == ~$past(buf_data[MSB]))
    else $error("result not offset binary");
  a_msb_first: assert property (            // [R18]
    fall_ev && !started_r && cs_act ##1 cs_act |=>
    dout_rdy_out == $past(shreg_r[MSB], 2))
    else $error("first bit is not the top bit");

endmodule

// ==== dv/pca_host_model.sv ====
// Purpose: Host side model reading the converter's serial port
// Assumes: Bench resolves the shared pins; clock pin pulled high
// Notes:   Samples on rising serial clock in both modes
`timescale 1ns/1ps
module pca_host_model (
  input  wire logic clk_in,
  input  wire logic sclk_pin_in,
  input  wire logic dout_pin_in,
  output      logic sclk_drv_out,
  output      logic sclk_drv_oe_out
);
  logic [23:0] word;
  int          falls;
  time         t_fall1;
  time         t_fall2;

  initial begin
    sclk_drv_out    = 1'h1;
    sclk_drv_oe_out = 1'h0;
    word            = 24'h0;
    falls           = 0;
  end

  // Bit taken on each rising edge, first bit ends up on top
  always @(posedge sclk_pin_in) begin
    word = {word[22:0], dout_pin_in};
  end

  always @(negedge sclk_pin_in) begin
    falls = falls + 1;
    if (falls == 1) t_fall1 = $time;
    if (falls == 2) t_fall2 = $time;
  end

  task automatic clear();
    word  = 24'h0;
    falls = 0;
  endtask

  // Low phase longer than high: line settles well before sampling
  task automatic read(input int batch);
    @(posedge clk_in);
    sclk_drv_oe_out <= 1'h1;
    for (int i = 0; i < 24; i++) begin
      if (i != 0 && i % batch == 0) repeat (8) @(posedge clk_in);
      @(posedge clk_in);
      sclk_drv_out <= 1'h0;
      repeat (6) @(posedge clk_in);
      sclk_drv_out <= 1'h1;
      repeat (3) @(posedge clk_in);
    end
    @(posedge clk_in);
    sclk_drv_oe_out <= 1'h0;
  endtask
endmodule

// ==== dv/pca_readout_test.sv ====
// Purpose: Self-checking bench for the converter serial readout
// Assumes: Shortened conversion period and lock wait
// Notes:   Bench plays the front end; host model reads words
`timescale 1ns/1ps
module pca_readout_test;
  import pca_pkg::*;
  localparam int  CONV = 48;
  localparam time XT   = 64;
  logic        clk_in    = 1'h0;
  logic        resetn_in = 1'h0;
  logic        crystal_osc_clock      = 1'h0;
  logic        cs_n      = 1'h1;
  logic        mode      = 1'h0;
  logic        pair      = 1'h0;
  logic        src_valid = 1'h0;
  logic [23:0] src_word  = 24'h0;
  logic        dout_last = 1'h1;
  logic        sclk_out, sclk_oe, dout, dout_oe, src_ready, pair_out, conv;
  logic        h_sclk, h_oe, sclk_pin, dout_pin;
  logic [23:0] rw;
  int          error_cnt = 0;
  int          compares  = 0;
  int          seed      = 92;
  int          batch [3] = '{24, 8, 3};
  logic [23:0] corner [3] = '{24'h800000, 24'h000000, 24'h7fffff};
  time         t0, t_rdy, t_nxt;
  bit          ok;

  // ------------------------------------------------------------------
  // Clocks, pins and design
  // ------------------------------------------------------------------
  always #4 clk_in = ~clk_in;
  initial begin
    #5;
    forever #32 crystal_osc_clock = ~crystal_osc_clock;
  end
  // Released line shows the inverse of its last driven level
  assign sclk_pin = sclk_oe ? sclk_out : (h_oe ? h_sclk : 1'h1);
  assign dout_pin = dout_oe ? dout : ~dout_last;
  always @(posedge clk_in) begin
    if (dout_oe) dout_last <= dout;
    src_valid <= resetn_in;
  end

  pca_readout #(.CONV_PERIOD(CONV), .PLL_LOCK(2)) i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .crystal_osc_clock_in(crystal_osc_clock),
    .cs_n_in(cs_n), .mode_in(mode), .input_pair_select_in(pair),
    .sclk_in(sclk_pin), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe),
    .dout_rdy_out(dout), .dout_rdy_oe_out(dout_oe),
    .result_valid_in(src_valid), .result_ready_out(src_ready),
    .result_data_in(src_word), .pair_select_out(pair_out),
    .converting_out(conv));

  pca_host_model i_host (
    .clk_in(clk_in), .sclk_pin_in(sclk_pin), .dout_pin_in(dout_pin),
    .sclk_drv_out(h_sclk), .sclk_drv_oe_out(h_oe));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [23:0] exp_code(input logic [23:0] d);
    return {~d[23], d[22:0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wait_line(input logic lvl, output time t);
    int n;
    n = 0;
    while (!(dout_oe === 1'h1 && dout_pin === lvl) && n < 3000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n == 3000) begin
      error_cnt++;
      $display("[FAIL] line level wait timed out");
      stop_test();
    end
    t = $time;
  endtask

  task automatic select(input logic m, input logic p, input logic [23:0] d);
    @(posedge clk_in);
    cs_n <= 1'h1;
    repeat (8) @(posedge clk_in);
    mode     <= m;
    pair     <= p;
    src_word <= d;
    repeat (8) @(posedge clk_in);
    i_host.clear();
    cs_n <= 1'h0;
    t0 = $time;
    ok = 1'b0;
    for (int i = 0; i < 12 && !ok; i++) begin
      @(posedge clk_in);
      #1;
      ok = dout_oe;
    end
    check("line busy at start", dout, LINE_BUSY);
  endtask

  task automatic run_master(input logic [23:0] d, input logic p);
    int n;
    select(1'h0, p, d);
    wait_line(1'h0, t_rdy);
    check("settle", t_rdy - t0 >= 2 * CONV * XT, 1);
    check("pair", pair_out, p);
    for (n = 0; i_host.falls < 24 && n < 2000; n++) @(posedge clk_in);
    repeat (40) @(posedge clk_in);
    #1;
    check("master word", i_host.word, exp_code(d));
    check("clock count", i_host.falls, 24);
    check("clock idle", sclk_pin, SCLK_IDLE);
    check("master drives", sclk_oe, 1'h1);
    check("period", i_host.t_fall2 - i_host.t_fall1 inside {[56:72]}, 1);
    check("low first", i_host.t_fall1 - t_rdy >= XT / 2 - 8, 1);
    wait_line(1'h0, t_nxt);
    check("rate", t_nxt - t_rdy inside {[CONV*XT-24:CONV*XT+24]}, 1);
  endtask

  task automatic run_slave(input logic [23:0] d, input logic p, input int b);
    select(1'h1, p, d);
    wait_line(1'h0, t_rdy);
    check("slave leaves clock", sclk_oe, 1'h0);
    check("pair", pair_out, p);
    i_host.read(b);
    repeat (8) @(posedge clk_in);
    #1;
    check("slave word", i_host.word, exp_code(d));
    check("busy after read", dout, LINE_BUSY);
  endtask

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    #700000;
    error_cnt++;
    $display("[FAIL] run time limit reached");
    stop_test();
  end

  initial begin
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'h1;
    #1;
    check("reset line float", dout_oe, 1'h0);
    check("reset clock idle", sclk_out, SCLK_IDLE);
    foreach (corner[i]) begin
      run_master(corner[i], i[0]);
      $display("master test %0d done", i);
    end
    for (int k = 0; k < 3; k++) begin
      rw = 24'($random(seed));
      run_slave(rw, k[0], batch[k]);
      $display("slave test %0d done", k);
    end
    // Unread word: line must rise before the next update
    select(1'h1, 1'h0, 24'h123456);
    wait_line(1'h0, t_rdy);
    wait_line(1'h1, t_nxt);
    check("unread release", t_nxt - t_rdy < CONV * XT, 1);
    wait_line(1'h0, t0);
    check("release lead", t0 - t_nxt >= XT / 2, 1);
    $display("unread test done");
    // Deselect with a word pending, then a fresh word must come
    repeat (40) @(posedge clk_in);
    #1;
    check("converting", conv, 1'h1);
    @(posedge clk_in);
    cs_n <= 1'h1;
    repeat (8) @(posedge clk_in);
    #1;
    check("line floated", dout_oe, 1'h0);
    check("clock floated", sclk_oe, 1'h0);
    check("standby", conv, 1'h0);
    check("words discarded", src_ready, 1'h1);
    rw = 24'($random(seed));
    run_slave(rw, 1'h1, 8);
    $display("abort test done");
    // Reset in mid-run while selected
    @(posedge clk_in);
    resetn_in <= 1'h0;
    @(posedge clk_in);
    #1;
    check("reset float mid", dout_oe, 1'h0);
    check("reset standby", conv, 1'h0);
    check("reset clock mid", sclk_oe, 1'h0);
    @(posedge clk_in);
    resetn_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    #1;
    check("after reset idle", conv, 1'h0);
    $display("reset test done");
    stop_test();
  end
endmodule
